// file: core/cirp_pkg.sv
// Shared constants and types for the charger identity/reset/precharge register slice
package cirp_pkg;
  localparam logic [7:0] REG_IDENT = 8'h03;
  localparam logic [7:0] REG_SOFT_RST = 8'h04;
  localparam logic [7:0] REG_PROT_PRECH = 8'h05;
  localparam logic [7:0] PROT_PRECH_RESET = 8'h93;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam int SOFT_RST_BIT = 7;
  localparam int UV_SEL_BIT = 7;
  localparam int BOOST_OC_BIT = 6;
  localparam int FLOOR_HI = 5;
  localparam int FLOOR_LO = 4;
  localparam int PRECH_HI = 3;
  localparam int PRECH_LO = 0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [9:0] BOOST_OC_LOW_MA = 10'h1f4;
  localparam logic [9:0] BOOST_OC_HIGH_MA = 10'h3e8;
  localparam logic [11:0] FLOOR_BASE_MV = 12'hdac;
  localparam logic [11:0] FLOOR_STEP_MV = 12'h064;
  localparam logic [9:0] PRECH_BASE_MA = 10'h064;
  localparam logic [9:0] PRECH_STEP_MA = 10'h032;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_REG = 9'h008,
    ST_RACK = 9'h010,
    ST_WR = 9'h020,
    ST_WACK = 9'h040,
    ST_RD = 9'h080,
    ST_MACK = 9'h100
  } cirp_state_t;

  function automatic logic [11:0] cirp_floor_mv(input logic [1:0] code);
    cirp_floor_mv = 12'(FLOOR_BASE_MV + FLOOR_STEP_MV * 12'(code));
  endfunction : cirp_floor_mv

  function automatic logic [9:0] cirp_prech_ma(input logic [3:0] code);
    cirp_prech_ma = 10'(PRECH_BASE_MA + PRECH_STEP_MA * 10'(code));
  endfunction : cirp_prech_ma
endpackage : cirp_pkg

// file: core/cirp_bus_if.sv
// Internal register access bundle between serial engine and register bank
`timescale 1ns/100ps
`default_nettype none
interface cirp_bus_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic soft_rst;
  logic uv_sel;
  logic boost_oc;
  logic [1:0] floor_code;
  logic [3:0] prech_code;
  modport engine(output wr_en, output addr, output wdata, input rdata, input soft_rst,
                 input uv_sel, input boost_oc, input floor_code, input prech_code);
  modport bank(input wr_en, input addr, input wdata, output rdata, output soft_rst,
               output uv_sel, output boost_oc, output floor_code, output prech_code);
endinterface : cirp_bus_if
`default_nettype wire

// file: core/cirp_regs.sv
// Register bank: identity, soft reset and protection/precharge control
`timescale 1ns/100ps
`default_nettype none
module cirp_regs #(
  parameter logic [3:0] MAKER_CODE = 4'ha,    // Arbitrary value
  parameter logic [3:0] SILICON_REV = 4'h1    // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  cirp_bus_if.bank bus
);
  import cirp_pkg::*;

  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic soft_rst_q;
  wire sel_ident = (bus.addr == REG_IDENT);
  wire sel_rst = (bus.addr == REG_SOFT_RST);
  wire sel_prot = (bus.addr == REG_PROT_PRECH);
  wire rst_req = bus.wr_en && sel_rst && bus.wdata[SOFT_RST_BIT];  // [RL1]

  // Soft reset returns this register to its default, so a later write in the same cycle loses
  assign prot_d = rst_req ? PROT_PRECH_RESET :
                  (bus.wr_en && sel_prot) ? bus.wdata : prot_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prot_q <= PROT_PRECH_RESET;
      soft_rst_q <= 1'b0;
    end else begin
      prot_q <= prot_d;
      soft_rst_q <= rst_req;  // [RL1]
    end
  end

  // Identity is constant and writes to it have no path; soft reset always reads zero
  assign bus.rdata = sel_ident ? {MAKER_CODE, SILICON_REV} :  // [RL7]
                     sel_prot ? prot_q :
                     READ_NONE;  // [RL2]
  assign bus.soft_rst = soft_rst_q;
  assign bus.uv_sel = prot_q[UV_SEL_BIT];
  assign bus.boost_oc = prot_q[BOOST_OC_BIT];
  assign bus.floor_code = prot_q[FLOOR_HI:FLOOR_LO];
  assign bus.prech_code = prot_q[PRECH_HI:PRECH_LO];
endmodule : cirp_regs
`default_nettype wire

// file: core/cirp_top.sv
// Two-wire serial register port and control outputs of the charger register slice
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: Writing one to the soft-reset bit puts the charger in reset; zero does nothing.
// RL2: The soft-reset bit always reads back as zero.
// RL3: Undervolt select: zero keeps switching on undervoltage, one stops switching.
// RL4: Boost overcurrent bit picks 0.5 A (zero) or 1 A (one) threshold.
// RL5: System floor code 00..11 selects 3.5, 3.6, 3.7, 3.8 volts.
// RL6: Precharge code selects 100 mA plus 50 mA per code step, 650 mA at 1011.
// RL7: Identity reads maker code high nibble, revision low nibble; writes ignored.
module cirp_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,     // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'ha,    // Arbitrary value
  parameter logic [3:0] SILICON_REV = 4'h1    // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sys_uv_in,
  output logic charger_reset,
  output logic switching_en,
  output logic boost_oc_sel,
  output logic [9:0] boost_oc_ma,
  output logic [1:0] system_floor_voltage,
  output logic [11:0] system_floor_mv,
  output logic [3:0] precharge_current,
  output logic [9:0] precharge_ma
);
  import cirp_pkg::*;

  cirp_bus_if bus ();

  cirp_regs #(
    .MAKER_CODE(MAKER_CODE),
    .SILICON_REV(SILICON_REV)
  ) u_regs (
    .clk(clk),
    .nrst(nrst),
    .bus(bus)
  );

  // Pin synchronisers; only the second stage and its delayed copy feed logic
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic uv_m_q;
  logic uv_s_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      uv_m_q <= 1'b0;
      uv_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      uv_m_q <= sys_uv_in;
      uv_s_q <= uv_m_q;
    end
  end

  wire scl_rise = scl_s_q && !scl_p_q;
  wire scl_fall = !scl_s_q && scl_p_q;
  wire start_det = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
  wire stop_det = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

  cirp_state_t state_q;
  logic [2:0] cnt_q;
  logic [6:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rw_q;
  logic ack_q;
  logic sda_oe_q;

  wire [7:0] byte_in = {shift_q, sda_s_q};
  wire byte_done = (cnt_q == BIT_LAST);
  wire addr_hit = (byte_in[7:1] == DEV_ADDR);
  wire [7:0] ptr_inc = 8'(ptr_q + 8'h01);

  assign bus.wr_en = wr_q;
  assign bus.addr = ptr_q;
  assign bus.wdata = wdata_q;

  // Serial engine: samples on SCL rise, changes SDA on SCL fall, open-drain low only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      shift_q <= 7'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 3'h0;
        ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_REG, ST_WR: begin
            shift_q <= byte_in[6:0];
            cnt_q <= 3'(cnt_q + 3'h1);
            if (byte_done) begin
              if (state_q == ST_ADDR) begin
                state_q <= addr_hit ? ST_AACK : ST_IDLE;
                rw_q <= byte_in[0];
              end else if (state_q == ST_REG) begin
                state_q <= ST_RACK;
                ptr_q <= byte_in;
              end else begin
                state_q <= ST_WACK;
                wdata_q <= byte_in;
                wr_q <= 1'b1;  // [RL7]
              end
            end
          end
          ST_RD: begin
            cnt_q <= 3'(cnt_q + 3'h1);
            if (byte_done) begin
              state_q <= ST_MACK;
            end
          end
          ST_MACK: begin
            // Host acknowledge asks for the next register; a not-acknowledge ends the read
            if (sda_s_q) begin
              state_q <= ST_IDLE;
            end else begin
              ptr_q <= ptr_inc;
              ack_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_AACK, ST_RACK, ST_WACK: begin
            if (!ack_q) begin
              ack_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end else begin
              ack_q <= 1'b0;
              cnt_q <= 3'h0;
              if (state_q == ST_AACK && rw_q) begin
                state_q <= ST_RD;
                tx_q <= bus.rdata;
                sda_oe_q <= !bus.rdata[7];
              end else begin
                state_q <= (state_q == ST_AACK) ? ST_REG : ST_WR;
                sda_oe_q <= 1'b0;
                if (state_q == ST_WACK) begin
                  ptr_q <= ptr_inc;
                end
              end
            end
          end
          ST_RD: begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_q <= !tx_q[6];
          end
          ST_MACK: begin
            sda_oe_q <= 1'b0;
            if (ack_q) begin
              ack_q <= 1'b0;
              cnt_q <= 3'h0;
              state_q <= ST_RD;
              tx_q <= bus.rdata;
              sda_oe_q <= !bus.rdata[7];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Control outputs, registered so downstream analog sees clean levels
  logic charger_reset_q;
  logic switching_en_q;
  logic boost_oc_sel_q;
  logic [9:0] boost_oc_ma_q;
  logic [1:0] floor_q;
  logic [11:0] floor_mv_q;
  logic [3:0] prech_q;
  logic [9:0] prech_ma_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      charger_reset_q <= 1'b0;
      switching_en_q <= 1'b1;
      boost_oc_sel_q <= 1'b0;
      boost_oc_ma_q <= BOOST_OC_LOW_MA;
      floor_q <= PROT_PRECH_RESET[FLOOR_HI:FLOOR_LO];
      floor_mv_q <= FLOOR_BASE_MV;
      prech_q <= PROT_PRECH_RESET[PRECH_HI:PRECH_LO];
      prech_ma_q <= PRECH_BASE_MA;
    end else begin
      charger_reset_q <= bus.soft_rst;  // [RL1]
      switching_en_q <= !(uv_s_q && bus.uv_sel);  // [RL3]
      boost_oc_sel_q <= bus.boost_oc;
      boost_oc_ma_q <= bus.boost_oc ? BOOST_OC_HIGH_MA : BOOST_OC_LOW_MA;  // [RL4]
      floor_q <= bus.floor_code;
      floor_mv_q <= cirp_floor_mv(bus.floor_code);  // [RL5]
      prech_q <= bus.prech_code;
      prech_ma_q <= cirp_prech_ma(bus.prech_code);  // [RL6]
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;
  assign charger_reset = charger_reset_q;
  assign switching_en = switching_en_q;
  assign boost_oc_sel = boost_oc_sel_q;
  assign boost_oc_ma = boost_oc_ma_q;
  assign system_floor_voltage = floor_q;
  assign system_floor_mv = floor_mv_q;
  assign precharge_current = prech_q;
  assign precharge_ma = prech_ma_q;
endmodule : cirp_top
`default_nettype wire

// file: verif/cirp_top_monitor.sv
// Port checker for the charger register slice
`timescale 1ns/100ps
`default_nettype none
module cirp_top_monitor
  import cirp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sys_uv_in,
  input wire logic charger_reset,
  input wire logic switching_en,
  input wire logic boost_oc_sel,
  input wire logic [9:0] boost_oc_ma,
  input wire logic [1:0] system_floor_voltage,
  input wire logic [11:0] system_floor_mv,
  input wire logic [3:0] precharge_current,
  input wire logic [9:0] precharge_ma
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_sda_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_boost_ma_map: assert property (
    boost_oc_ma == (boost_oc_sel ? BOOST_OC_HIGH_MA : BOOST_OC_LOW_MA)) else $error("boost limit");
  // The reset mA and mV figures disagree with the reset codes until the first clock after reset release
  a_floor_mv_map: assert property ($past(nrst) |->
    system_floor_mv == FLOOR_BASE_MV + FLOOR_STEP_MV * system_floor_voltage) else $error("floor mv");
  a_prech_ma_map: assert property ($past(nrst) |->
    precharge_ma == PRECH_BASE_MA + PRECH_STEP_MA * precharge_current) else $error("precharge ma");
  a_reset_one_pulse: assert property (charger_reset |=> !charger_reset) else $error("reset pulse");
  a_reset_from_bus: assert property (charger_reset |-> scl_in) else $error("reset off bus");
  a_uv_idle_on: assert property ((!sys_uv_in)[*4] |=> switching_en) else $error("uv gate");
  a_uv_off_cause: assert property (!switching_en |-> $past(sys_uv_in, 3)) else $error("uv off");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved in high");
  a_ctrl_scl_high: assert property ($past(nrst, 2) &&
    $changed({boost_oc_sel, system_floor_voltage, precharge_current}) |-> scl_in) else $error("ctrl");
endmodule : cirp_top_monitor
bind cirp_top cirp_top_monitor u_mon (.*);
`default_nettype wire

// file: verif/cirp_host.sv
// Behavioural host mastering the two-wire register port
`timescale 1ns/100ps
`default_nettype none
module cirp_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hc
  // s=1 start or repeated start, s=0 stop; SDA moves with SCL high only here
  task automatic cond(input logic s);
    sda_low = !s;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_low = s;
    hc(8);
    scl = !s;
    hc(4);
  endtask : cond
  // Phases of 4 clocks, twice the minimum, leave room for the pin synchronisers
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hc(4);
    scl = 1'b1;
    hc(4);
    r = sda;
    hc(4);
    scl = 1'b0;
    hc(4);
  endtask : bit_io
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b0}, k1);
    wbyte(a, k2);
    wbyte(d, k3);
    cond(1'b0);
    ok = k1 & k2 & k3;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b0}, k);
    wbyte(a, k);
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    cond(1'b0);
  endtask : rd
  // Two data bytes after one pointer byte, so the pointer has to step in between
  task automatic wr2(input logic [7:0] a, input logic [15:0] d, output logic ok);
    logic k1, k2, k3, k4;
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b0}, k1);
    wbyte(a, k2);
    wbyte(d[15:8], k3);
    wbyte(d[7:0], k4);
    cond(1'b0);
    ok = k1 & k2 & k3 & k4;
  endtask : wr2
  // The host acknowledges the first byte to get the next register, then ends with a not-acknowledge
  task automatic rd2(input logic [7:0] a, output logic [15:0] d);
    logic k;
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b0}, k);
    wbyte(a, k);
    cond(1'b1);
    wbyte({DEV_ADDR, 1'b1}, k);
    for (int i = 15; i >= 8; i--) bit_io(1'b1, d[i]);
    bit_io(1'b0, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    cond(1'b0);
  endtask : rd2
endmodule : cirp_host
`default_nettype wire

// file: verif/test_cirp_top.sv
// Bench for the charger register slice
`timescale 1ns/100ps
`default_nettype none
module test_cirp_top;
  import cirp_pkg::*;
  logic clk, nrst, scl_in, sda_out, sda_oe, sys_uv_in, charger_reset, switching_en, boost_oc_sel, h_low;
  logic [9:0] boost_oc_ma, precharge_ma;
  logic [1:0] system_floor_voltage;
  logic [11:0] system_floor_mv;
  logic [3:0] precharge_current;
  wire logic sda_in = !(h_low | sda_oe);
  int failures = 0;
  int n_tests = 0;
  int pulses = 0;
  cirp_top #(.MAKER_CODE(4'h6), .SILICON_REV(4'h2)) dut (.*);
  cirp_host host (.clk(clk), .sda(sda_in), .scl(scl_in), .sda_low(h_low));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (charger_reset === 1'b1) pulses++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    check(ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask : rd
  task automatic t_reset();
    check({charger_reset, switching_en, sda_oe}, 3'h2);
    check({boost_oc_sel, boost_oc_ma}, 11'h1f4);
    check({system_floor_voltage, system_floor_mv}, {2'h1, 12'he10});
    check({precharge_current, precharge_ma}, {4'h3, 10'h0fa});
    rd(REG_PROT_PRECH, 8'h93);
  endtask : t_reset
  task automatic t_ident();
    logic ok;
    rd(REG_IDENT, 8'h62);
    wr(REG_IDENT, 8'h00);
    rd(REG_IDENT, 8'h62);
    rd(8'h07, 8'h00);
    host.cond(1'b1);
    host.wbyte(8'h10, ok);
    host.cond(1'b0);
    check(ok, 1'b0);
  endtask : t_ident
  task automatic t_soft();
    wr(REG_PROT_PRECH, 8'h55);
    wr(REG_SOFT_RST, 8'h00);
    rd(REG_PROT_PRECH, 8'h55);
    wr(REG_SOFT_RST, 8'hff);
    check(16'(pulses), 16'h1);
    rd(REG_SOFT_RST, 8'h00);
    rd(REG_PROT_PRECH, 8'h93);
  endtask : t_soft
  // Burst transfers: pointer steps after each written byte and each acknowledged read byte
  task automatic t_burst();
    logic ok;
    logic [15:0] v;
    host.wr2(REG_SOFT_RST, 16'h00a6, ok);
    check(ok, 1'b1);
    check(16'(pulses), 16'h1);
    host.rd2(REG_IDENT, v);
    check(v, 16'h6200);
    host.rd2(REG_SOFT_RST, v);
    check(v, 16'h00a6);
  endtask : t_burst
  task automatic t_fields();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(REG_PROT_PRECH, {1'b0, c[0], c[1:0], c});
      check({boost_oc_sel, boost_oc_ma}, {c[0], c[0] ? 10'h3e8 : 10'h1f4});
      check({system_floor_voltage, system_floor_mv}, {c[1:0], 12'hdac + 12'h064 * c[1:0]});
      check({precharge_current, precharge_ma}, {c, 10'h064 + 10'h032 * c});
    end
  endtask : t_fields
  // Six clocks cover the pin synchroniser and the output register
  task automatic set_uv(input logic b, input logic exp);
    sys_uv_in = b;
    repeat (6) @(posedge clk);
    #1;
    check(switching_en, exp);
  endtask : set_uv
  task automatic t_uv();
    wr(REG_PROT_PRECH, 8'h80);
    set_uv(1'b1, 1'b0);
    set_uv(1'b0, 1'b1);
    wr(REG_PROT_PRECH, 8'h00);
    set_uv(1'b1, 1'b1);
    set_uv(1'b0, 1'b1);
  endtask : t_uv
  initial begin
    nrst = 1'b0;
    sys_uv_in = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_ident();
    t_soft();
    t_burst();
    t_fields();
    t_uv();
    report_and_stop();
  end
  // About 34 transfers of at most 800 clocks each; allow roughly twice that
  initial begin
    #2200000;
    failures++;
    report_and_stop();
  end
endmodule : test_cirp_top
`default_nettype wire
